/* File: dcb_params.svh */
// Functional notes
// R1: Host assigns addresses and top flag first
// R2: Broadcast read has zero payload length
// R3: Every device answers; top device first
// R4: Device waits for frame from above
// R5: Bad upstream CRC: no append, fault
// R6: Response is data plus six bytes
// R7: Response carries own device address
// R8: Read length byte is count minus one
// R9: Write accepted unaddressed, up to eight
// R10: Write length field is count minus one
// R11: Every device executes broadcast writes
// R12: Broadcast read initial byte is C0
// R13: Broadcast write initial byte from D0
// R14: Reverse broadcast write byte is E0
// R15: Frame on wrong port flags error
// R16: Reverse write on wrong port accepted
// R17: Reverse write should touch direction only; the code writes its data byte to whatever address it carries
// R18: Direction bit is bit 7 of 0x0309
// R19: True on positive, complement on negative
// R20: Ports switch transmit/receive automatically
// R21: Wake loads direction and top role
// R22: Debug controls override both ports
// R23: Frames end in two-byte CRC
`ifndef DCB_PARAMS_SVH
`define DCB_PARAMS_SVH
`define DCB_INIT_RD   8'hC0
`define DCB_INIT_WR   8'hD0
`define DCB_INIT_RV   8'hE0
`define DCB_WR_MASK   8'hF8
`define DCB_REQ_RD    3'h4
`define DCB_PROTO     8'h06
`define DCB_CTRL_ADDR 16'h0309
`define DCB_CTRL_RST  8'h00
`define DCB_DIR_BIT   7
`define DCB_CRC_POLY  16'hA001
`define DCB_CRC_INIT  16'hFFFF
`define DCB_CLK_MHZ   200
`define DCB_TMO_US    10
`define DCB_TMO_CYC   (`DCB_TMO_US * `DCB_CLK_MHZ)
`endif

/* File: dcb_pkg.sv */
`include "dcb_params.svh"
package dcb_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_CMD  = 3'h1,
    DS_EXEC = 3'h2,
    DS_WAIT = 3'h3,
    DS_RESP = 3'h4
  } dcb_dst_t;
  typedef enum logic [1:0] {
    HS_IDLE   = 2'h0,
    HS_SEND   = 2'h1,
    HS_LISTEN = 2'h2
  } dcb_hst_t;
  typedef enum logic [1:0] {
    CK_READ  = 2'h0,
    CK_WRITE = 2'h1,
    CK_REV   = 2'h2
  } dcb_kind_t;

  // Reflected CRC-16, one byte; residual is zero over a whole frame
  function automatic logic [15:0] dcb_crc_step(input logic [15:0] c,
                                               input logic [7:0]  b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `DCB_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
endpackage

/* File: dcb_link_if.sv */
`timescale 1ns/100ps
interface dcb_link_if;
  logic       h_stb;
  logic       h_sof;
  logic [7:0] h_true;
  logic [7:0] h_comp;
  logic       h_oe_n;
  logic       d_stb;
  logic       d_sof;
  logic [7:0] d_true;
  logic [7:0] d_comp;
  logic       d_oe_n;
  modport dev  (input  h_stb, h_sof, h_true, h_comp, h_oe_n,
                output d_stb, d_sof, d_true, d_comp, d_oe_n);
  modport host (output h_stb, h_sof, h_true, h_comp, h_oe_n,
                input  d_stb, d_sof, d_true, d_comp, d_oe_n);
endinterface

/* File: dcb_host.sv */
`timescale 1ns/100ps
`include "dcb_params.svh"
module dcb_host (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  dcb_link_if.host               lnk,
  input  wire logic              cmd_go,
  input  wire dcb_pkg::dcb_kind_t cmd_kind,
  input  wire logic [15:0]       cmd_addr,
  input  wire logic [2:0]        cmd_size,
  input  wire logic [7:0]        cmd_rlen,
  input  wire logic [63:0]       cmd_wdata,
  input  wire logic [3:0]        exp_frames,
  output logic                   busy,
  output logic                   rsp_stb,
  output logic                   rsp_sof,
  output logic [7:0]             rsp_byte,
  output logic                   frm_ok,
  output logic                   frm_bad,
  output logic                   timeout
);
  import dcb_pkg::*;

  dcb_hst_t    st_r, st_nxt;
  dcb_kind_t   kind_r;
  logic [7:0]  k_r, len_r, init_r, rlen_r;
  logic [15:0] addr_r, crc_r, tmo_r;
  logic [63:0] wd_r;
  logic [3:0]  frames_r, exp_r;

  ////////////////////////////////////////////////////////////////////////
  wire go = (st_r == HS_IDLE) & cmd_go;
  wire [7:0] go_init = (cmd_kind == CK_READ)  ? `DCB_INIT_RD :        // [R12]
                       (cmd_kind == CK_WRITE) ?
                       (`DCB_INIT_WR | {5'h00, cmd_size}) :         // [R13] [R10]
                       `DCB_INIT_RV;                                // [R14]
  wire [7:0] go_len = (cmd_kind == CK_WRITE) ?                 // [R17]
                      ({5'h00, cmd_size} + `DCB_PROTO) : `DCB_PROTO; // [R2]
  wire s_last = (st_r == HS_SEND) & (k_r == len_r - 8'h01);
  wire s_data = (k_r > 8'h02) & (k_r < len_r - 8'h02);
  // Read sends the encoded length; reverse write carries one data byte
  wire [7:0] s_byte = (k_r == 8'h00) ? init_r :
                      (k_r == 8'h01) ? addr_r[15:8] :
                      (k_r == 8'h02) ? addr_r[7:0] :
                      (k_r == len_r - 8'h02) ? crc_r[7:0] :         // [R23]
                      (k_r == len_r - 8'h01) ? crc_r[15:8] :
                      (kind_r == CK_READ) ? rlen_r : wd_r[7:0];     // [R8]
  wire d_ok = lnk.d_stb & (lnk.d_comp == ~lnk.d_true);
  wire r_take = (st_r == HS_LISTEN) & d_ok & (lnk.d_sof | k_r != 8'h00);
  wire r_last = r_take & (k_r != 8'h00) & (k_r == len_r - 8'h01);
  wire [15:0] crc_base = (k_r == 8'h00) ? `DCB_CRC_INIT : crc_r;
  wire [15:0] crc_new = dcb_crc_step(crc_base,
                                     (st_r == HS_SEND) ? s_byte : lnk.d_true);
  wire tmo_hit = (st_r == HS_LISTEN) & (tmo_r == 16'(`DCB_TMO_CYC));
  wire all_in = r_last & (frames_r + 4'h1 == exp_r);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HS_IDLE:   if (go) st_nxt = HS_SEND;
      HS_SEND: begin
        if (s_last) begin
          st_nxt = (kind_r == CK_READ && exp_r != 4'h0) ? HS_LISTEN : HS_IDLE;
        end
      end
      HS_LISTEN: if (all_in | tmo_hit) st_nxt = HS_IDLE;
      default:   st_nxt = HS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= HS_IDLE;      kind_r <= CK_READ;   k_r <= 8'h00;
      len_r <= 8'h00;       init_r <= 8'h00;     rlen_r <= 8'h00;
      addr_r <= 16'h0000;   crc_r <= 16'h0000;   tmo_r <= 16'h0000;
      wd_r <= 64'h0;        frames_r <= 4'h0;    exp_r <= 4'h0;
    end else if (ce) begin
      st_r <= st_nxt;
      if (go) begin
        kind_r <= cmd_kind; init_r <= go_init; len_r <= go_len;
        addr_r <= cmd_addr; rlen_r <= cmd_rlen; wd_r <= cmd_wdata;
        exp_r <= exp_frames; frames_r <= 4'h0;
      end
      if (st_r == HS_SEND) begin
        if (k_r < len_r - 8'h02) crc_r <= crc_new;                  // [R23]
        k_r <= s_last ? 8'h00 : k_r + 8'h01;
        if (s_data) wd_r <= wd_r >> 8;
      end else if (r_take) begin
        crc_r <= crc_new;
        k_r <= r_last ? 8'h00 : k_r + 8'h01;
        if (k_r == 8'h00) len_r <= {1'b0, lnk.d_true[6:0]} + 8'h01 + `DCB_PROTO;
        if (r_last) frames_r <= frames_r + 4'h1;
      end
      tmo_r <= (st_r != HS_LISTEN || d_ok) ? 16'h0000 : tmo_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.h_stb <= 1'b0;  lnk.h_sof <= 1'b0;  lnk.h_oe_n <= 1'b1;
      lnk.h_true <= 8'h00; lnk.h_comp <= 8'hFF;
      busy <= 1'b0;  rsp_stb <= 1'b0;  rsp_sof <= 1'b0;  rsp_byte <= 8'h00;
      frm_ok <= 1'b0;  frm_bad <= 1'b0;  timeout <= 1'b0;
    end else if (ce) begin
      lnk.h_stb <= (st_r == HS_SEND);
      lnk.h_sof <= (st_r == HS_SEND) & (k_r == 8'h00);
      lnk.h_oe_n <= ~(st_r == HS_SEND);
      lnk.h_true <= s_byte;                                         // [R19]
      lnk.h_comp <= ~s_byte;
      busy <= (st_nxt != HS_IDLE);
      rsp_stb <= r_take;
      rsp_sof <= r_take & (k_r == 8'h00);
      rsp_byte <= lnk.d_true;
      frm_ok <= r_last & (crc_new == 16'h0000);
      frm_bad <= r_last & (crc_new != 16'h0000);
      timeout <= tmo_hit;
    end
  end
endmodule

/* File: dcb_dev.sv */
`timescale 1ns/100ps
`include "dcb_params.svh"
module dcb_dev (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  dcb_link_if.dev          lnk,
  input  wire logic        up_rx_stb,
  input  wire logic        up_rx_sof,
  input  wire logic [7:0]  up_rx_true,
  input  wire logic [7:0]  up_rx_comp,
  output logic             up_tx_stb,
  output logic             up_tx_sof,
  output logic [7:0]       up_tx_true,
  output logic [7:0]       up_tx_comp,
  output logic             up_oe_n,
  input  wire logic [7:0]  dev_addr,
  input  wire logic        top_flag,
  input  wire logic        is_base,
  input  wire logic        wake,
  input  wire logic        dbg_unlock,
  input  wire logic [7:0]  ovr_ctrl_a,
  input  wire logic [7:0]  ovr_ctrl_b,
  output logic [15:0]      reg_rd_addr,
  input  wire logic [7:0]  reg_rdata,
  output logic             reg_wr_en,
  output logic [15:0]      reg_wr_addr,
  output logic [7:0]       reg_wr_data,
  output logic [7:0]       primary_ctrl,
  output logic             crc_fault,
  output logic             comm_err
);
  import dcb_pkg::*;

  dcb_dst_t    st_r, st_nxt;
  logic        dir_r, top_r, src_far_r;
  logic [7:0]  init_r, cnt_r, len_r, rlen_r;
  logic [15:0] raddr_r, crc_r;
  logic [2:0]  wi_r;
  logic [7:0]  wbuf [0:7];

  ////////////////////////////////////////////////////////////////////////
  // Near port faces the host; base device keeps its host side below
  wire near_up = dir_r & ~is_base;                                  // [R20]
  wire lo_ok = lnk.h_stb & (lnk.h_comp == ~lnk.h_true);             // [R19]
  wire up_ok = up_rx_stb & (up_rx_comp == ~up_rx_true);             // [R19]
  wire n_ok = near_up ? up_ok : lo_ok;
  wire n_sof = near_up ? up_rx_sof : lnk.h_sof;
  wire [7:0] n_byte = near_up ? up_rx_true : lnk.h_true;
  wire f_ok = near_up ? lo_ok : up_ok;
  wire f_sof = near_up ? lnk.h_sof : up_rx_sof;
  wire [7:0] f_byte = near_up ? lnk.h_true : up_rx_true;

  wire n_bc = (n_byte == `DCB_INIT_RD) |                            // [R12] [R2]
              ((n_byte & `DCB_WR_MASK) == `DCB_INIT_WR) |           // [R13]
              (n_byte == `DCB_INIT_RV);                             // [R14]
  wire n_start = n_ok & n_sof & n_bc;
  wire f_start = f_ok & f_sof & (f_byte == `DCB_INIT_RV);           // [R16]
  wire idle = (st_r == DS_IDLE);
  wire idle_go = idle & (n_start | f_start);
  // Far port is legal only for responses or a reverse write in flight
  wire f_wrong = f_ok & f_sof & ~(idle & f_start) &                 // [R15]
                 (st_r != DS_WAIT) & ~((st_r == DS_CMD) & src_far_r);

  wire from_far = idle ? ~n_start : src_far_r;
  wire c_ok = from_far ? f_ok : n_ok;
  wire c_sof = from_far ? f_sof : n_sof;
  wire [7:0] c_byte = from_far ? f_byte : n_byte;
  wire c_take = idle_go | ((st_r == DS_CMD) & c_ok);
  // Upstream frame must open with its start byte
  wire w_take = (st_r == DS_WAIT) & f_ok & (f_sof | cnt_r != 8'h00); // [R4]
  wire take = c_take | w_take;
  wire [7:0] rx_byte = w_take ? f_byte : c_byte;
  wire rx_last = take & (cnt_r != 8'h00) & (cnt_r == len_r - 8'h01);
  wire is_wr = ((init_r & `DCB_WR_MASK) == `DCB_INIT_WR);
  wire [2:0] w_cnt = is_wr ? init_r[2:0] : 3'h0;                    // [R10]
  wire [7:0] c_len = ((c_byte & `DCB_WR_MASK) == `DCB_INIT_WR) ?
                     ({5'h00, c_byte[2:0]} + `DCB_PROTO) : `DCB_PROTO;
  wire [7:0] w_len = {1'b0, f_byte[6:0]} + 8'h01 + `DCB_PROTO;      // [R6]
  wire [7:0] r_len = {1'b0, rlen_r[6:0]} + 8'h01 + `DCB_PROTO;      // [R6] [R8]
  wire [7:0] widx = cnt_r - 8'h03;

  ////////////////////////////////////////////////////////////////////////
  // Own response; read data lags one cycle behind the address
  wire resp = (st_r == DS_RESP);
  wire r_last = resp & (cnt_r == len_r - 8'h01);
  wire [7:0] rd_data = (reg_rd_addr == `DCB_CTRL_ADDR) ? primary_ctrl
                                                       : reg_rdata;
  wire [7:0] tx_byte = (cnt_r == 8'h00) ? {1'b0, rlen_r[6:0]} :
                       (cnt_r == 8'h01) ? dev_addr :                // [R7]
                       (cnt_r == 8'h02) ? raddr_r[15:8] :
                       (cnt_r == 8'h03) ? raddr_r[7:0] :
                       (cnt_r == len_r - 8'h02) ? crc_r[7:0] :      // [R23]
                       (cnt_r == len_r - 8'h01) ? crc_r[15:8] : rd_data;
  wire [15:0] crc_base = (cnt_r == 8'h00) ? `DCB_CRC_INIT : crc_r;
  wire [15:0] crc_new = dcb_crc_step(crc_base, resp ? tx_byte : rx_byte);
  wire crc_good = (crc_new == 16'h0000);                            // [R23]
  // Sent CRC bytes must not fold back into the register they come from
  wire crc_hold = resp & (cnt_r >= len_r - 8'h02);

  // Top device has nobody above, so commands stop there
  wire o_near = resp | w_take | (c_take & from_far);
  wire o_stb = resp | w_take | (c_take & (from_far | ~top_r));
  wire o_sof = resp ? (cnt_r == 8'h00) : (w_take ? f_sof : c_sof);
  wire [7:0] o_byte = resp ? tx_byte : rx_byte;
  wire o_up = o_near ? near_up : ~near_up;
  wire a_near = (st_r == DS_WAIT) | resp | ((st_r == DS_CMD) & src_far_r);
  wire a_far = (st_r == DS_CMD) & ~src_far_r & ~top_r;
  wire drv_up_a = (o_stb & o_up) | (near_up ? a_near : a_far);      // [R20]
  wire drv_lo_a = (o_stb & ~o_up) | (near_up ? a_far : a_near);     // [R20]
  wire ovr_up = dbg_unlock & ovr_ctrl_a[0];
  wire ovr_lo = dbg_unlock & ovr_ctrl_b[0];
  wire drv_up = ovr_up ? ovr_ctrl_a[1] : drv_up_a;                  // [R22]
  wire drv_lo = ovr_lo ? ovr_ctrl_b[1] : drv_lo_a;                  // [R22]
  wire [15:0] wr_addr = raddr_r + {13'h0000, wi_r};
  // Control register lives here, not in the user register file
  wire wr_ctrl = (st_r == DS_EXEC) & (wr_addr == `DCB_CTRL_ADDR);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DS_IDLE: if (idle_go) st_nxt = DS_CMD;
      DS_CMD: begin
        if (rx_last) begin
          if (!crc_good) st_nxt = DS_IDLE;
          else if (init_r[6:4] == `DCB_REQ_RD) begin
            st_nxt = top_r ? DS_RESP : DS_WAIT;                     // [R3]
          end else st_nxt = DS_EXEC;                                // [R11] [R9]
        end
      end
      DS_EXEC: if (wi_r == w_cnt) st_nxt = DS_IDLE;
      DS_WAIT: if (rx_last) st_nxt = crc_good ? DS_RESP : DS_IDLE;  // [R4] [R5]
      DS_RESP: if (r_last) st_nxt = DS_IDLE;
      default: st_nxt = DS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= DS_IDLE;    cnt_r <= 8'h00;    len_r <= 8'h00;
      init_r <= 8'h00;    rlen_r <= 8'h00;   src_far_r <= 1'b0;
      raddr_r <= 16'h0000; crc_r <= 16'h0000; wi_r <= 3'h0;
      for (int i = 0; i < 8; i++) wbuf[i] <= 8'h00;
    end else if (ce) begin
      st_r <= st_nxt;
      if (idle_go) begin
        cnt_r <= 8'h01; len_r <= c_len;
        init_r <= c_byte; src_far_r <= ~n_start;
      end else if (st_nxt != st_r) begin
        cnt_r <= 8'h00;
        if (st_nxt == DS_RESP) len_r <= r_len;
      end else if (take | resp) begin
        cnt_r <= cnt_r + 8'h01;
        if (w_take & (cnt_r == 8'h00)) len_r <= w_len;
      end
      if (take | (resp & ~crc_hold)) crc_r <= crc_new;             // [R23]
      if (c_take & (cnt_r == 8'h01)) raddr_r[15:8] <= c_byte;
      if (c_take & (cnt_r == 8'h02)) raddr_r[7:0] <= c_byte;
      if (c_take & (cnt_r == 8'h03)) rlen_r <= c_byte;
      if (c_take & (cnt_r > 8'h02) & (widx < 8'h08)) wbuf[widx[2:0]] <= c_byte;
      wi_r <= (st_r == DS_EXEC) ? wi_r + 3'h1 : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Direction only takes effect at wake, so a chain flips as one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_r <= 1'b0;  top_r <= 1'b0;  primary_ctrl <= `DCB_CTRL_RST;
      reg_wr_en <= 1'b0;  reg_wr_addr <= 16'h0000;  reg_wr_data <= 8'h00;
      reg_rd_addr <= 16'h0000;  crc_fault <= 1'b0;  comm_err <= 1'b0;
    end else if (ce) begin
      if (wake) begin
        dir_r <= primary_ctrl[`DCB_DIR_BIT];                        // [R21]
        top_r <= top_flag;                                          // [R21]
      end
      if (wr_ctrl) primary_ctrl <= wbuf[wi_r];                      // [R18]
      reg_wr_en <= (st_r == DS_EXEC) & ~wr_ctrl;                    // [R11]
      reg_wr_addr <= wr_addr;
      reg_wr_data <= wbuf[wi_r];
      reg_rd_addr <= raddr_r + {8'h00, cnt_r} - 16'h0003;
      crc_fault <= (st_r == DS_WAIT) & rx_last & ~crc_good;         // [R5]
      comm_err <= f_wrong | ((st_r == DS_CMD) & rx_last & ~crc_good); // [R15]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      up_tx_stb <= 1'b0;  up_tx_sof <= 1'b0;  up_oe_n <= 1'b1;
      up_tx_true <= 8'h00;  up_tx_comp <= 8'hFF;
      lnk.d_stb <= 1'b0;  lnk.d_sof <= 1'b0;  lnk.d_oe_n <= 1'b1;
      lnk.d_true <= 8'h00;  lnk.d_comp <= 8'hFF;
    end else if (ce) begin
      up_tx_stb <= o_stb & o_up & drv_up;
      up_tx_sof <= o_sof;
      up_oe_n <= ~drv_up;
      up_tx_true <= o_byte;                                         // [R19]
      up_tx_comp <= ~o_byte;
      lnk.d_stb <= o_stb & ~o_up & drv_lo;
      lnk.d_sof <= o_sof;
      lnk.d_oe_n <= ~drv_lo;
      lnk.d_true <= o_byte;                                         // [R19]
      lnk.d_comp <= ~o_byte;
    end
  end
endmodule

/* File: dcb_link_chk.sv */
`timescale 1ns/100ps
package dcb_tb_pkg;
  // Own copy of the link CRC, kept apart from the design's
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) x = x[0] ? (x >> 1) ^ 16'hA001 : x >> 1;
    return x;
  endfunction
endpackage
////////////////////////////////////////////////////////////////////////////
module dcb_link_chk (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       h_stb,
  input wire logic       h_sof,
  input wire logic [7:0] h_true,
  input wire logic [7:0] h_comp,
  input wire logic       h_oe_n,
  input wire logic       d_stb,
  input wire logic       d_sof,
  input wire logic [7:0] d_true,
  input wire logic [7:0] d_comp,
  input wire logic       d_oe_n
);
  import dcb_tb_pkg::*;
  logic [4:0]  h_cnt_r, h_need_r;
  logic [7:0]  d_cnt_r, d_need_r;
  logic [15:0] h_crc_r;
  wire  [4:0]  h_need_nxt = (h_true[7:4] == 4'hD) ?
                            5'(h_true[2:0]) + 5'h06 : 5'h06;
  // A relayed reverse write runs downward as a plain six-byte frame
  wire  [7:0]  d_need_nxt = d_true[7] ? 8'h06 :
                            {1'b0, d_true[6:0]} + 8'h07;
  // Byte count and running CRC per host frame
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      h_cnt_r <= 5'h00;
      h_need_r <= 5'h00;
      h_crc_r <= 16'h0000;
    end else if (h_stb) begin
      h_cnt_r <= h_sof ? 5'h01 : h_cnt_r + 5'h01;
      h_need_r <= h_sof ? h_need_nxt : h_need_r;
      h_crc_r <= crc_byte(h_sof ? 16'hFFFF : h_crc_r, h_true);
    end
  end
  // Device side: count only, relayed frames may carry a bad CRC
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      d_cnt_r <= 8'h00;
      d_need_r <= 8'h00;
    end else if (d_stb) begin
      d_cnt_r <= d_sof ? 8'h01 : d_cnt_r + 8'h01;
      d_need_r <= d_sof ? d_need_nxt : d_need_r;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  host_comp_a: assert property (h_stb |-> h_comp == ~h_true)
    else $error("host complement byte wrong");
  dev_comp_a: assert property (d_stb |-> d_comp == ~d_true)
    else $error("device complement byte wrong");
  host_drive_a: assert property (h_stb |-> !h_oe_n)
    else $error("host strobe without drive");
  dev_drive_a: assert property (d_stb |-> !d_oe_n)
    else $error("device strobe without drive");
  half_duplex_a: assert property (!(!h_oe_n && !d_oe_n))
    else $error("both ends drive the link");
  init_code_a: assert property (h_stb && h_sof |->
    h_true == 8'hC0 || h_true[7:3] == 5'h1A || h_true == 8'hE0)
    else $error("bad command start byte");
  cmd_len_a: assert property ($fell(h_stb) |-> h_cnt_r == h_need_r)
    else $error("command length wrong");
  cmd_crc_a: assert property ($fell(h_stb) |-> h_crc_r == 16'h0000)
    else $error("command CRC residual nonzero");
  rsp_len_a: assert property ($fell(d_stb) |-> d_cnt_r == d_need_r)
    else $error("response length wrong");
  rsp_init_a: assert property (d_stb && d_sof |->
    !d_true[7] || d_true == 8'hE0)
    else $error("response start byte wrong");
endmodule

/* File: daisy_chain_broadcast_commands_tb_top.sv */
`timescale 1ns/100ps
`define CHK(act, exp) \
  begin \
    cmp_count++; \
    if ((act) !== (exp)) begin \
      failures++; \
      $display("wrong value at %0t: %h, expected %h", $time, act, exp); \
    end \
  end
module daisy_chain_broadcast_commands_tb_top;
  import dcb_pkg::*;
  import dcb_tb_pkg::*;
  logic        sys_clk = 1'b0, arst_n = 1'b0, ce = 1'b1, cmd_go = 1'b0;
  dcb_kind_t   cmd_kind = CK_READ;
  logic [15:0] cmd_addr = 16'h0000;
  logic [2:0]  cmd_size = 3'h0;
  logic [7:0]  cmd_rlen = 8'h00;
  logic [63:0] cmd_wdata = 64'h0;
  logic [3:0]  exp_frames = 4'h0;
  logic        up_rx_stb = 1'b0, up_rx_sof = 1'b0, wake = 1'b0;
  logic [7:0]  up_rx_true = 8'h00, up_rx_comp = 8'hFF, dev_addr = 8'h00;
  logic        top_flag = 1'b0, is_base = 1'b0, dbg_unlock = 1'b0;
  logic [7:0]  ovr_ctrl_a = 8'h00, ovr_ctrl_b = 8'h00;
  logic        busy, rsp_stb, rsp_sof, frm_ok, frm_bad, timeout;
  logic        up_tx_stb, up_tx_sof, up_oe_n, reg_wr_en, crc_fault, comm_err;
  logic [7:0]  rsp_byte, reg_rdata, reg_wr_data, primary_ctrl;
  logic [7:0]  up_tx_true, up_tx_comp, eb, f[$], rsp_q[$];
  logic [15:0] reg_rd_addr, reg_wr_addr, a;
  logic [23:0] ew, wr_q[$];
  logic [31:0] rng = 32'hBC12;
  logic [2:0]  wsz [3] = '{3'h0, 3'h3, 3'h7};
  logic [7:0]  rls [2] = '{8'h00, 8'h1F};
  int          failures = 0, cmp_count = 0, cyc = 0, e0 = 0, rsp_left = 0;
  int          ok_n = 0, bad_n = 0, cf_n = 0, er_n = 0, to_n = 0;
  // Register file stand-in: data is a fixed function of the address
  assign reg_rdata = reg_rd_addr[7:0] ^ 8'h3C;
  always #2.5 sys_clk = ~sys_clk;
  dcb_link_if lnk ();
  dcb_host u_dcb_host (.sys_clk, .arst_n, .ce, .lnk, .cmd_go, .cmd_kind,
    .cmd_addr, .cmd_size, .cmd_rlen, .cmd_wdata, .exp_frames, .busy,
    .rsp_stb, .rsp_sof, .rsp_byte, .frm_ok, .frm_bad, .timeout);
  dcb_dev u_dcb_dev (.sys_clk, .arst_n, .ce, .lnk, .up_rx_stb, .up_rx_sof,
    .up_rx_true, .up_rx_comp, .up_tx_stb, .up_tx_sof, .up_tx_true,
    .up_tx_comp, .up_oe_n, .dev_addr, .top_flag, .is_base, .wake,
    .dbg_unlock, .ovr_ctrl_a, .ovr_ctrl_b, .reg_rd_addr, .reg_rdata,
    .reg_wr_en, .reg_wr_addr, .reg_wr_data, .primary_ctrl, .crc_fault,
    .comm_err);
  dcb_link_chk u_dcb_link_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .h_stb(lnk.h_stb), .h_sof(lnk.h_sof), .h_true(lnk.h_true),
    .h_comp(lnk.h_comp), .h_oe_n(lnk.h_oe_n), .d_stb(lnk.d_stb),
    .d_sof(lnk.d_sof), .d_true(lnk.d_true), .d_comp(lnk.d_comp),
    .d_oe_n(lnk.d_oe_n));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic void add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) c = crc_byte(c, q[i]);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction
  task automatic own_frame(input logic [15:0] ad, input logic [7:0] rl);
    logic [7:0] q[$];
    q = {rl, dev_addr, ad[15:8], ad[7:0]};
    for (int i = 0; i <= int'(rl); i++) q.push_back(8'(ad + 16'(i)) ^ 8'h3C);
    add_crc(q);
    rsp_q = {rsp_q, q};
  endtask
  task automatic host_cmd(input dcb_kind_t k, input logic [15:0] ad,
      input logic [2:0] sz, input logic [7:0] rl, input logic [3:0] nf);
    int n;
    @(posedge sys_clk);
    cmd_kind <= k;
    cmd_addr <= ad;
    cmd_size <= sz;
    cmd_rlen <= rl;
    exp_frames <= nf;
    cmd_go <= 1'b1;
    @(posedge sys_clk);
    cmd_go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge sys_clk);
    repeat (14) @(posedge sys_clk);
  endtask
  // Device above: bytes back to back, lines scrambled once released
  task automatic up_frame(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge sys_clk);
      up_rx_stb <= 1'b1;
      up_rx_sof <= (i == 0);
      up_rx_true <= q[i];
      up_rx_comp <= ~q[i];
    end
    @(posedge sys_clk);
    up_rx_stb <= 1'b0;
    up_rx_sof <= 1'b0;
    up_rx_true <= ~up_rx_true;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic relay_read(input logic [7:0] q[$]);
    int n;
    fork
      host_cmd(CK_READ, 16'h0540, 3'h0, 8'h03, 4'h2);
      begin
        for (n = 0; n < 40 && up_tx_sof !== 1'b1; n++) @(posedge sys_clk);
        `CHK(up_tx_true, 8'hC0)
        `CHK({up_tx_comp, up_oe_n, up_tx_stb}, {8'h3F, 2'b01})
        repeat (10) @(posedge sys_clk);
        up_frame(q);
      end
    join
  endtask
  task automatic pulse_wake();
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Result watcher: an empty queue forces a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (rsp_stb === 1'b1) begin
      eb = (rsp_q.size() > 0) ? rsp_q.pop_front() : ~rsp_byte;
      `CHK(rsp_byte, eb)
      `CHK(rsp_sof, rsp_left == 0)
      rsp_left = (rsp_left == 0) ? int'(eb[6:0]) + 6 : rsp_left - 1;
    end
    if (reg_wr_en === 1'b1) begin
      ew = (wr_q.size() > 0) ? wr_q.pop_front() : ~{reg_wr_addr, reg_wr_data};
      `CHK({reg_wr_addr, reg_wr_data}, ew)
    end
    if (frm_ok === 1'b1) ok_n++;
    if (frm_bad === 1'b1) bad_n++;
    if (crc_fault === 1'b1) cf_n++;
    if (comm_err === 1'b1) er_n++;
    if (timeout === 1'b1) to_n++;
    if (cyc == 12000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK(primary_ctrl, 8'h00)
    foreach (wsz[j]) begin
      rng = xs(rng);
      a = {8'h10, rng[7:0]};
      cmd_wdata <= {rng, xs(rng)};
      @(posedge sys_clk);
      for (int i = 0; i <= wsz[j]; i++)
        wr_q.push_back({a + 16'(i), cmd_wdata[8*i +: 8]});
      host_cmd(CK_WRITE, a, wsz[j], 8'h00, 4'h0);
    end
    `CHK(wr_q.size(), 0)
    dev_addr <= rng[15:8];
    top_flag <= 1'b1;
    pulse_wake();
    foreach (rls[j]) begin
      rng = xs(rng);
      a = {8'h05, rng[7:0]};
      own_frame(a, rls[j]);
      host_cmd(CK_READ, a, 3'h0, rls[j], 4'h1);
    end
    `CHK(ok_n, 2)
    top_flag <= 1'b0;
    pulse_wake();
    f = {8'h03, 8'h22, 8'h05, 8'h40, rng[7:0], rng[15:8], rng[23:16], 8'h9A};
    add_crc(f);
    rsp_q = {rsp_q, f};
    own_frame(16'h0540, 8'h03);
    relay_read(f);
    `CHK(ok_n, 4)
    f[9] = ~f[9];
    rsp_q = {rsp_q, f};
    relay_read(f);
    `CHK({cf_n, bad_n, to_n, ok_n}, {32'd1, 32'd1, 32'd1, 32'd4})
    cmd_wdata <= 64'h0;
    host_cmd(CK_REV, 16'h0309, 3'h0, 8'h00, 4'h0);
    e0 = er_n;
    f = {8'hE0, 8'h03, 8'h09, 8'h80};
    add_crc(f);
    up_frame(f);
    `CHK({primary_ctrl, 8'(er_n - e0)}, 16'h8000)
    f = {8'hD0, 8'h10, 8'h00, 8'h55};
    add_crc(f);
    up_frame(f);
    `CHK(er_n - e0, 1)
    pulse_wake();
    host_cmd(CK_WRITE, 16'h1000, 3'h0, 8'h00, 4'h0);
    `CHK(er_n - e0, 2)
    `CHK(rsp_q.size() + wr_q.size(), 0)
    tally_and_finish();
  end
endmodule
